// ---- uart_mode_pkg.sv ----
// Purpose: constants and types for the uart mode and register select block
// Assumes: 8-bit host register port, 3 address lines
// Notes: offsets are address-line values
package uart_mode_pkg;
    localparam logic [2:0] ADDR_DATA = 3'h0;
    localparam logic [2:0] ADDR_MASK = 3'h1;
    localparam logic [2:0] ADDR_FIFO = 3'h2;
    localparam logic [2:0] ADDR_LINE = 3'h3;
    localparam logic [2:0] ADDR_TX_FILL = 3'h4;
    localparam logic [2:0] ADDR_INDEX_DATA = 3'h5;
    localparam logic [2:0] ADDR_INDEX = 3'h7;
    localparam logic [7:0] BANK_KEY = 8'hbf;
    localparam logic [7:0] IDX_ADDITIONAL = 8'h00;
    localparam logic [7:0] IDX_PRESCALER = 8'h01;
    localparam logic [7:0] IDX_EXT_CLOCK = 8'h02;
    localparam logic [7:0] IDX_OVERSAMPLE = 8'h03;
    localparam logic [5:0] IDX_TRIG_GROUP = 6'h01;
    localparam logic [5:0] IDX_ID_GROUP = 6'h02;
    localparam logic [7:0] PRESCALER_RESET = 8'h20;
    localparam logic [7:0] OVERSAMPLE_RESET = 8'h00;
    localparam logic [3:0] OVERSAMPLE_MIN = 4'h4;
    localparam logic [4:0] OVERSAMPLE_DEFAULT = 5'h10;
    localparam logic [7:0] EIGHTHS_PER_CLOCK = 8'h08;
    localparam int FIFO_ON_BIT = 0;
    localparam int DEEP_BIT = 5;
    localparam int DIVISOR_BIT = 7;
    localparam int ENHANCED_BIT = 4;
    localparam int ARB_LEVELS_BIT = 5;
    localparam int INDEXED_BIT = 6;
    localparam int EXTRA_BIT = 7;
    localparam int RX_EXT_BIT = 0;
    localparam int TX_EXT_BIT = 1;
    localparam int DTR_OUT_BIT = 2;

    typedef enum logic [1:0] {DEPTH_1, DEPTH_16, DEPTH_128} depth_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [2:0] addr;
        logic [7:0] wdata;
    } host_req_t;

    typedef struct packed {
        logic fifo_enabled;
        logic compat_features_en;
        logic enhanced_features_en;
        logic arbitrary_levels_en;
        logic [3:0] fifo_trigger;
        logic [3:0][7:0] levels;
        logic [4:0] samples_per_bit;
        logic [15:0] divisor;
        logic [7:0] interrupt_mask;
        logic [6:0] data_format;
    } features_t;
endpackage : uart_mode_pkg

// ---- uart_mode_and_register_select.sv ----
// Purpose: mode selection, register decode, prescaler and clock options of a uart
// Assumes: host_req is synchronous to clk; serial pins are asynchronous
// Notes: rdata follows a read strobe by one cycle
//
// Functional notes
// RQ1 - depth pin high plus fifo enable: 128
// RQ2 - depth pin low: 16, depth bit 128
// RQ3 - depth bit written only while divisor bit set
// RQ4 - compatible extras only while enhanced bit clear
// RQ5 - enhanced with fifo enable always 128 deep
// RQ6 - enhanced mode enables extra feature group
// RQ7 - arbitrary levels ignore fifo trigger bits
// RQ8 - prescaler divides clock by M plus N/8
// RQ9 - prescaler resets to divide by four
// RQ10 - external clocks from ring and dsr pins
// RQ11 - tx clock on dtr, clock select index
// RQ12 - oversampling 0..3 gives 16, else value
// RQ13 - divisor bit maps low slots to divisor
// RQ14 - 0xbf opens bank, sets bit seven only
// RQ15 - extra and indexed registers exposed by control
// RQ16 - address zero writes tx, reads rx
// RQ17 - reset clears fifo enable, single entry
// RQ18 - fifo disabled ignores all mode settings, but arbitrary_levels_en and fifo_trigger still follow their control bits
// RQ19 - four byte read-only identification code
`timescale 1ns/1ps
module uart_mode_and_register_select #(
    parameter logic [31:0] ID_CODE = 32'h5a3c_0001 // arbitrary value
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire uart_mode_pkg::host_req_t host_req,
    input wire logic [7:0] rx_data,
    input wire logic [7:0] rx_level,
    input wire logic [7:0] tx_level,
    input wire logic depth_select_pin,
    input wire logic ring_clock_pin,
    input wire logic dsr_clock_pin,
    output logic [7:0] rdata,
    output logic [7:0] tx_data,
    output logic tx_load,
    output logic rx_pop,
    output uart_mode_pkg::depth_t fifo_depth,
    output uart_mode_pkg::features_t features,
    output logic baud_tick,
    output logic tx_bit_clk,
    output logic rx_bit_clk,
    output logic dtr_pin
);
    typedef struct packed {
        logic [2:0] pin_s1;
        logic [2:0] pin_s2;
        logic [7:0] line_control;
        logic bank_open;
        logic [7:0] divisor_low_byte;
        logic [7:0] divisor_high_byte;
        logic [7:0] interrupt_mask;
        logic [7:0] fifo_control;
        logic [7:0] enhanced_feature;
        logic [7:0] additional_control;
        logic [7:0] clock_prescaler;
        logic [7:0] external_clock_select;
        logic [7:0] oversampling_rate;
        logic [3:0][7:0] trig;
        logic [7:0] index;
        logic [7:0] acc;
        logic [7:0] rdata;
        logic [7:0] tx_data;
        logic tx_load;
        logic rx_pop;
        uart_mode_pkg::depth_t depth;
        uart_mode_pkg::features_t feat;
        logic tick;
        logic tx_clk;
        logic rx_clk;
        logic dtr;
    } state_t;

    state_t s;
    state_t next_s;
    logic divisor_mode;
    logic pin_depth;
    logic pin_ring;
    logic pin_dsr;
    logic enhanced;
    logic [7:0] ratio;
    logic [8:0] sum;
    logic [7:0] indexed_value;
    logic [7:0] status_value;
    logic [3:0][7:0] id_bytes;

    // ***********************************
    // indexed register read mux
    // ***********************************
    assign id_bytes = ID_CODE;
    always_comb begin
        indexed_value = 8'h00;
        if (s.index[7:2] == uart_mode_pkg::IDX_TRIG_GROUP) begin
            indexed_value = s.trig[s.index[1:0]];
        end else if (s.index[7:2] == uart_mode_pkg::IDX_ID_GROUP) begin
            indexed_value = id_bytes[2'h3 - s.index[1:0]]; // RQ19
        end else begin
            case (s.index)
                uart_mode_pkg::IDX_ADDITIONAL: indexed_value = s.additional_control;
                uart_mode_pkg::IDX_PRESCALER: indexed_value = s.clock_prescaler;
                uart_mode_pkg::IDX_EXT_CLOCK: indexed_value = s.external_clock_select;
                uart_mode_pkg::IDX_OVERSAMPLE: indexed_value = s.oversampling_rate;
                default: indexed_value = 8'h00;
            endcase
        end
    end

    // ***********************************
    // next state
    // ***********************************
    always_comb begin
        next_s = s;
        divisor_mode = s.line_control[uart_mode_pkg::DIVISOR_BIT];
        pin_depth = s.pin_s2[2];
        pin_ring = s.pin_s2[1];
        pin_dsr = s.pin_s2[0];
        enhanced = s.enhanced_feature[uart_mode_pkg::ENHANCED_BIT];
        status_value = {1'b0, s.depth == uart_mode_pkg::DEPTH_128, pin_depth, 5'h00};
        next_s.pin_s1 = {depth_select_pin, ring_clock_pin, dsr_clock_pin};
        next_s.pin_s2 = s.pin_s1;
        next_s.tx_load = 1'b0;
        next_s.rx_pop = 1'b0;

        if (host_req.wr) begin
            unique case (host_req.addr)
                uart_mode_pkg::ADDR_DATA: begin
                    if (divisor_mode) begin
                        next_s.divisor_low_byte = host_req.wdata; // RQ13
                    end else begin
                        next_s.tx_data = host_req.wdata; // RQ16
                        next_s.tx_load = 1'b1; // RQ16
                    end
                end
                uart_mode_pkg::ADDR_MASK: begin
                    if (divisor_mode) begin
                        next_s.divisor_high_byte = host_req.wdata; // RQ13
                    end else begin
                        next_s.interrupt_mask = host_req.wdata;
                    end
                end
                uart_mode_pkg::ADDR_FIFO: begin
                    if (s.bank_open) begin
                        next_s.enhanced_feature = host_req.wdata;
                    end else begin
                        next_s.fifo_control[3:0] = host_req.wdata[3:0];
                        if (!s.additional_control[uart_mode_pkg::ARB_LEVELS_BIT]) begin
                            next_s.fifo_control[7:6] = host_req.wdata[7:6]; // RQ7
                            next_s.fifo_control[4] = host_req.wdata[4]; // RQ7
                        end
                        if (divisor_mode) begin
                            next_s.fifo_control[uart_mode_pkg::DEEP_BIT] =
                                host_req.wdata[uart_mode_pkg::DEEP_BIT]; // RQ3
                        end
                    end
                end
                uart_mode_pkg::ADDR_LINE: begin
                    if (host_req.wdata == uart_mode_pkg::BANK_KEY) begin
                        next_s.line_control[uart_mode_pkg::DIVISOR_BIT] = 1'b1; // RQ14
                        next_s.bank_open = 1'b1; // RQ14
                    end else begin
                        next_s.line_control = host_req.wdata;
                        next_s.bank_open = 1'b0; // RQ14
                    end
                end
                uart_mode_pkg::ADDR_INDEX_DATA: begin
                    if (!s.bank_open && !divisor_mode) begin
                        if (s.index[7:2] == uart_mode_pkg::IDX_TRIG_GROUP) begin
                            next_s.trig[s.index[1:0]] = host_req.wdata; // RQ7
                        end else begin
                            case (s.index)
                                uart_mode_pkg::IDX_ADDITIONAL: next_s.additional_control = host_req.wdata;
                                uart_mode_pkg::IDX_PRESCALER: next_s.clock_prescaler = host_req.wdata;
                                uart_mode_pkg::IDX_EXT_CLOCK: next_s.external_clock_select = host_req.wdata; // RQ11
                                uart_mode_pkg::IDX_OVERSAMPLE: next_s.oversampling_rate = host_req.wdata;
                                default: ;
                            endcase
                        end
                    end
                end
                uart_mode_pkg::ADDR_INDEX: begin
                    if (!s.bank_open) begin
                        next_s.index = host_req.wdata;
                    end
                end
                default: ;
            endcase
        end

        if (host_req.rd) begin
            next_s.rdata = 8'h00;
            unique case (host_req.addr)
                uart_mode_pkg::ADDR_DATA: begin
                    if (divisor_mode) begin
                        next_s.rdata = s.divisor_low_byte; // RQ13
                    end else begin
                        next_s.rdata = rx_data; // RQ16
                        next_s.rx_pop = 1'b1; // RQ16
                    end
                end
                uart_mode_pkg::ADDR_MASK: begin
                    if (divisor_mode) begin
                        next_s.rdata = s.divisor_high_byte; // RQ13
                    end else if (s.additional_control[uart_mode_pkg::EXTRA_BIT]) begin
                        next_s.rdata = status_value; // RQ15
                    end else begin
                        next_s.rdata = s.interrupt_mask;
                    end
                end
                uart_mode_pkg::ADDR_FIFO: begin
                    if (s.bank_open) begin
                        next_s.rdata = s.enhanced_feature;
                    end
                end
                uart_mode_pkg::ADDR_LINE: begin
                    if (s.additional_control[uart_mode_pkg::EXTRA_BIT] && !divisor_mode) begin
                        next_s.rdata = rx_level; // RQ15
                    end else begin
                        next_s.rdata = s.line_control;
                    end
                end
                uart_mode_pkg::ADDR_TX_FILL: begin
                    if (s.additional_control[uart_mode_pkg::EXTRA_BIT] && !divisor_mode) begin
                        next_s.rdata = tx_level; // RQ15
                    end
                end
                uart_mode_pkg::ADDR_INDEX_DATA: begin
                    if (s.additional_control[uart_mode_pkg::INDEXED_BIT]) begin
                        next_s.rdata = indexed_value; // RQ15
                    end
                end
                uart_mode_pkg::ADDR_INDEX: next_s.rdata = s.index;
                default: ;
            endcase
        end

        // mode selection
        if (!s.fifo_control[uart_mode_pkg::FIFO_ON_BIT]) begin
            next_s.depth = uart_mode_pkg::DEPTH_1; // RQ18
        end else if (enhanced) begin
            next_s.depth = uart_mode_pkg::DEPTH_128; // RQ5
        end else if (pin_depth) begin
            next_s.depth = uart_mode_pkg::DEPTH_128; // RQ1
        end else if (s.fifo_control[uart_mode_pkg::DEEP_BIT]) begin
            next_s.depth = uart_mode_pkg::DEPTH_128; // RQ2
        end else begin
            next_s.depth = uart_mode_pkg::DEPTH_16; // RQ2
        end
        next_s.feat.fifo_enabled = s.fifo_control[uart_mode_pkg::FIFO_ON_BIT];
        next_s.feat.compat_features_en = s.fifo_control[uart_mode_pkg::FIFO_ON_BIT] & ~enhanced; // RQ4
        next_s.feat.enhanced_features_en = s.fifo_control[uart_mode_pkg::FIFO_ON_BIT] & enhanced; // RQ6
        next_s.feat.arbitrary_levels_en = s.additional_control[uart_mode_pkg::ARB_LEVELS_BIT]; // RQ7
        next_s.feat.fifo_trigger = s.additional_control[uart_mode_pkg::ARB_LEVELS_BIT] ?
            4'h0 : s.fifo_control[7:4]; // RQ7
        next_s.feat.levels = s.trig;
        if (s.oversampling_rate[3:0] < uart_mode_pkg::OVERSAMPLE_MIN) begin
            next_s.feat.samples_per_bit = uart_mode_pkg::OVERSAMPLE_DEFAULT; // RQ12
        end else begin
            next_s.feat.samples_per_bit = {1'b0, s.oversampling_rate[3:0]}; // RQ12
        end
        next_s.feat.divisor = {s.divisor_high_byte, s.divisor_low_byte};
        next_s.feat.interrupt_mask = s.interrupt_mask;
        next_s.feat.data_format = s.line_control[6:0];

        // fractional prescaler counted in eighths of a clock
        if (!next_s.feat.enhanced_features_en || s.clock_prescaler < uart_mode_pkg::EIGHTHS_PER_CLOCK) begin
            ratio = uart_mode_pkg::EIGHTHS_PER_CLOCK;
        end else begin
            ratio = s.clock_prescaler; // RQ8
        end
        sum = {1'b0, s.acc} + {1'b0, uart_mode_pkg::EIGHTHS_PER_CLOCK};
        if (sum >= {1'b0, ratio}) begin
            next_s.tick = 1'b1; // RQ8
            next_s.acc = 8'(sum - {1'b0, ratio}); // RQ8
        end else begin
            next_s.tick = 1'b0;
            next_s.acc = sum[7:0];
        end

        // external clock options
        next_s.tx_clk = s.external_clock_select[uart_mode_pkg::TX_EXT_BIT] ? pin_ring : s.tick; // RQ10
        next_s.rx_clk = s.external_clock_select[uart_mode_pkg::RX_EXT_BIT] ? pin_dsr : s.tick; // RQ10
        next_s.dtr = s.external_clock_select[uart_mode_pkg::DTR_OUT_BIT] ? s.tx_clk : 1'b1; // RQ11
    end

    // ***********************************
    // state register
    // ***********************************
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s <= '0;
            s.fifo_control <= 8'h00; // RQ17
            s.depth <= uart_mode_pkg::DEPTH_1; // RQ17
            s.clock_prescaler <= uart_mode_pkg::PRESCALER_RESET; // RQ9
            s.oversampling_rate <= uart_mode_pkg::OVERSAMPLE_RESET;
            s.feat.samples_per_bit <= uart_mode_pkg::OVERSAMPLE_DEFAULT;
            s.dtr <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    assign rdata = s.rdata;
    assign tx_data = s.tx_data;
    assign tx_load = s.tx_load;
    assign rx_pop = s.rx_pop;
    assign fifo_depth = s.depth;
    assign features = s.feat;
    assign baud_tick = s.tick;
    assign tx_bit_clk = s.tx_clk;
    assign rx_bit_clk = s.rx_clk;
    assign dtr_pin = s.dtr;
endmodule : uart_mode_and_register_select

// ---- uart_mode_host_model.sv ----
// Purpose: host processor on the register port
// Assumes: requests change at the falling clk edge
// Notes: also supplies the external bit clocks
`timescale 1ns/1ps
module uart_mode_host_model (
    input wire logic clk,
    input wire logic [7:0] rdata,
    output uart_mode_pkg::host_req_t host_req,
    output logic ring_clock_pin,
    output logic dsr_clock_pin
);
    initial begin
        host_req = '0;
        ring_clock_pin = 1'b0;
        dsr_clock_pin = 1'b0;
    end
    // one access, released with inverted address and data
    task automatic acc(input logic w, input logic [2:0] a, input logic [7:0] d, output logic [7:0] q);
        @(negedge clk);
        host_req = {w, !w, a, d};
        @(negedge clk);
        q = rdata;
        host_req = {2'b00, ~a, ~d};
    endtask : acc
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        logic [7:0] q;
        acc(1'b1, a, d, q);
    endtask : wr
    task automatic rd(input logic [2:0] a, output logic [7:0] q);
        acc(1'b0, a, 8'h00, q);
    endtask : rd
    // guard opened, depth bit written, guard closed
    task automatic depth_bit(input logic [7:0] line_value, input logic [7:0] fifo_value);
        wr(3'h3, line_value | 8'h80);
        wr(3'h2, fifo_value);
        wr(3'h3, line_value);
    endtask : depth_bit
    task automatic clocks(input logic r, input logic d);
        @(negedge clk);
        ring_clock_pin = r;
        dsr_clock_pin = d;
    endtask : clocks
endmodule : uart_mode_host_model

// ---- uart_mode_and_register_select_props.sv ----
// Purpose: port checker for the mode and register select block
// Assumes: one clock domain
// Notes: bound to the design top
`timescale 1ns/1ps
module uart_mode_checker (
    input wire logic clk,
    input wire logic rst_b,
    input wire uart_mode_pkg::host_req_t host_req,
    input wire logic [7:0] rx_data,
    input wire logic [7:0] rx_level,
    input wire logic [7:0] tx_level,
    input wire logic depth_select_pin,
    input wire logic ring_clock_pin,
    input wire logic dsr_clock_pin,
    input wire logic [7:0] rdata,
    input wire logic [7:0] tx_data,
    input wire logic tx_load,
    input wire logic rx_pop,
    input wire uart_mode_pkg::depth_t fifo_depth,
    input wire uart_mode_pkg::features_t features,
    input wire logic baud_tick,
    input wire logic tx_bit_clk,
    input wire logic rx_bit_clk,
    input wire logic dtr_pin
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    property p_tx;
        tx_load |-> $past(host_req.wr && host_req.addr == 3'h0) && tx_data == $past(host_req.wdata);
    endproperty
    a_tx: assert property (p_tx) else $error("tx load not from slot zero write");
    property p_rx;
        rx_pop |-> $past(host_req.rd && host_req.addr == 3'h0) && rdata == $past(rx_data);
    endproperty
    a_rx: assert property (p_rx) else $error("rx pop not from slot zero read");
    property p_hold;
        !$past(host_req.rd) |-> $stable(rdata);
    endproperty
    a_hold: assert property (p_hold) else $error("read data moved without read");
    property p_compat;
        features.compat_features_en |-> features.fifo_enabled && !features.enhanced_features_en;
    endproperty
    a_compat: assert property (p_compat) else $error("compat extras on in enhanced mode");
    property p_enh;
        features.enhanced_features_en [*2] |-> fifo_depth == uart_mode_pkg::DEPTH_128;
    endproperty
    a_enh: assert property (p_enh) else $error("enhanced mode depth not 128");
    property p_off;
        $fell(features.fifo_enabled) |-> ##[0:2] fifo_depth == uart_mode_pkg::DEPTH_1;
    endproperty
    a_off: assert property (p_off) else $error("depth kept with fifo disabled");
    property p_over;
        features.samples_per_bit inside {[5'h04:5'h10]};
    endproperty
    a_over: assert property (p_over) else $error("samples per bit out of range");
    property p_arb;
        features.arbitrary_levels_en |-> features.fifo_trigger == 4'h0;
    endproperty
    a_arb: assert property (p_arb) else $error("fifo trigger bits used with arbitrary levels");
    property p_tick;
        !features.enhanced_features_en [*4] |-> baud_tick;
    endproperty
    a_tick: assert property (p_tick) else $error("tick missing without prescaler");
    c_tx: cover property (tx_load);
    c_enh: cover property (features.enhanced_features_en);
    c_arb: cover property (features.arbitrary_levels_en);
endmodule : uart_mode_checker
bind uart_mode_and_register_select uart_mode_checker u_chk (.clk(clk), .rst_b(rst_b), .host_req(host_req),
    .rx_data(rx_data), .rx_level(rx_level), .tx_level(tx_level), .depth_select_pin(depth_select_pin),
    .ring_clock_pin(ring_clock_pin), .dsr_clock_pin(dsr_clock_pin), .rdata(rdata), .tx_data(tx_data),
    .tx_load(tx_load), .rx_pop(rx_pop), .fifo_depth(fifo_depth), .features(features), .baud_tick(baud_tick),
    .tx_bit_clk(tx_bit_clk), .rx_bit_clk(rx_bit_clk), .dtr_pin(dtr_pin));

// ---- uart_mode_and_register_select_tb.sv ----
// Purpose: self-checking bench for the mode and register select block
// Assumes: host model drives the register port
// Notes: inputs change at the falling edge
`timescale 1ns/1ps
module uart_mode_and_register_select_tb;
    localparam logic [31:0] ID = 32'h3c5a_0f0e; // arbitrary value
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] rx_data = 8'h00;
    logic depth_select_pin = 1'b0;
    logic ring_clock_pin, dsr_clock_pin, tx_load, rx_pop, baud_tick, tx_bit_clk, rx_bit_clk, dtr_pin;
    logic [7:0] rdata, tx_data;
    uart_mode_pkg::host_req_t host_req;
    uart_mode_pkg::depth_t fifo_depth;
    uart_mode_pkg::features_t features;
    int err_count = 0;
    int num_checks = 0;
    int cyc = 0;
    uart_mode_host_model u_host (.clk(clk), .rdata(rdata), .host_req(host_req),
        .ring_clock_pin(ring_clock_pin), .dsr_clock_pin(dsr_clock_pin));
    uart_mode_and_register_select #(.ID_CODE(ID)) u_dut (.clk(clk), .rst_b(rst_b), .host_req(host_req),
        .rx_data(rx_data), .rx_level(8'h21), .tx_level(8'h12), .depth_select_pin(depth_select_pin),
        .ring_clock_pin(ring_clock_pin), .dsr_clock_pin(dsr_clock_pin), .rdata(rdata), .tx_data(tx_data),
        .tx_load(tx_load), .rx_pop(rx_pop), .fifo_depth(fifo_depth), .features(features),
        .baud_tick(baud_tick), .tx_bit_clk(tx_bit_clk), .rx_bit_clk(rx_bit_clk), .dtr_pin(dtr_pin));
    always #20 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            end_of_test();
        end
    end
    task automatic check(input string n, input logic [15:0] e, input logic [15:0] g);
        num_checks++;
        if (g !== e) begin
            err_count++;
            $display("[FAIL] %s expected %h got %h", n, e, g);
        end
    endtask : check
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : end_of_test
    task automatic do_reset();
        @(negedge clk);
        rst_b = 1'b0;
        repeat (12) @(negedge clk);
        rst_b = 1'b1;
    endtask : do_reset
    task automatic settle();
        repeat (5) @(negedge clk);
    endtask : settle
    task automatic wset(input logic [2:0] a, input logic [7:0] d);
        u_host.wr(a, d);
        settle();
    endtask : wset
    task automatic ixw(input logic [7:0] i, input logic [7:0] d);
        u_host.wr(3'h7, i);
        wset(3'h5, d);
    endtask : ixw
    task automatic ixr(input logic [7:0] i, output logic [7:0] q);
        u_host.wr(3'h7, i);
        u_host.rd(3'h5, q);
    endtask : ixr
    task automatic enhance();
        wset(3'h3, 8'hbf);
        wset(3'h2, 8'h10);
        wset(3'h3, 8'h03);
        wset(3'h2, 8'h01);
    endtask : enhance
    task automatic ticks(input int n, output logic [15:0] k);
        k = 16'h0000;
        repeat (n) begin
            @(negedge clk);
            k = k + {15'h0000, baud_tick};
        end
    endtask : ticks
    task automatic t_reset();
        logic [7:0] q;
        do_reset();
        settle();
        check("depth", uart_mode_pkg::DEPTH_1, fifo_depth);
        check("samples", 16'h0010, features.samples_per_bit);
        ixw(8'h00, 8'h40);
        ixr(8'h01, q);
        check("prescaler", 16'h0020, q);
        $display("t_reset done");
    endtask : t_reset
    task automatic t_depth();
        do_reset();
        wset(3'h2, 8'h01);
        check("depth", uart_mode_pkg::DEPTH_16, fifo_depth);
        wset(3'h2, 8'h21);
        check("depth", uart_mode_pkg::DEPTH_16, fifo_depth);
        depth_select_pin = 1'b1;
        settle();
        check("depth", uart_mode_pkg::DEPTH_128, fifo_depth);
        depth_select_pin = 1'b0;
        u_host.depth_bit(8'h00, 8'h21);
        settle();
        check("depth", uart_mode_pkg::DEPTH_128, fifo_depth);
        do_reset();
        enhance();
        check("depth", uart_mode_pkg::DEPTH_128, fifo_depth);
        check("enh", 16'h0001, features.enhanced_features_en);
        check("compat", 16'h0000, features.compat_features_en);
        wset(3'h2, 8'h00);
        check("depth", uart_mode_pkg::DEPTH_1, fifo_depth);
        check("enh", 16'h0000, features.enhanced_features_en);
        $display("t_depth done");
    endtask : t_depth
    task automatic t_regs();
        logic [7:0] q;
        do_reset();
        wset(3'h3, 8'h03);
        wset(3'h3, 8'hbf);
        check("format", 16'h0003, features.data_format);
        wset(3'h3, 8'h83);
        u_host.wr(3'h0, 8'h34);
        check("load", 16'h0000, tx_load);
        u_host.wr(3'h1, 8'h12);
        wset(3'h3, 8'h03);
        check("divisor", 16'h1234, features.divisor);
        u_host.wr(3'h0, 8'ha5);
        check("load", 16'h0001, tx_load);
        check("txdata", 16'h00a5, tx_data);
        rx_data = 8'h6c;
        u_host.rd(3'h0, q);
        check("rxdata", 16'h006c, q);
        check("pop", 16'h0001, rx_pop);
        $display("t_regs done");
    endtask : t_regs
    task automatic t_prescale();
        logic [15:0] k;
        do_reset();
        ticks(20, k);
        check("ticks", 16'd20, k);
        enhance();
        ixw(8'h01, 8'h14);
        ticks(160, k);
        check("ticks", 16'd64, k);
        ixw(8'h01, 8'h20);
        ticks(160, k);
        check("ticks", 16'd40, k);
        $display("t_prescale done");
    endtask : t_prescale
    task automatic t_ext();
        do_reset();
        ixw(8'h02, 8'h07);
        u_host.clocks(1'b1, 1'b0);
        settle();
        check("txclk", 16'h0001, tx_bit_clk);
        check("rxclk", 16'h0000, rx_bit_clk);
        u_host.clocks(1'b0, 1'b1);
        settle();
        check("rxclk", 16'h0001, rx_bit_clk);
        check("txclk", 16'h0000, tx_bit_clk);
        check("dtr", 16'h0000, dtr_pin);
        $display("t_ext done");
    endtask : t_ext
    task automatic t_over();
        logic [7:0] v [5] = '{8'h00, 8'h03, 8'h04, 8'h0d, 8'h0f};
        logic [4:0] e [5] = '{5'h10, 5'h10, 5'h04, 5'h0d, 5'h0f};
        do_reset();
        for (int i = 0; i < 5; i++) begin
            ixw(8'h03, v[i]);
            check("samples", e[i], features.samples_per_bit);
        end
        $display("t_over done");
    endtask : t_over
    task automatic t_arb();
        logic [7:0] q;
        do_reset();
        depth_select_pin = 1'b1;
        ixw(8'h00, 8'he0);
        wset(3'h2, 8'hf1);
        check("arb", 16'h0001, features.arbitrary_levels_en);
        check("trig", 16'h0000, features.fifo_trigger);
        ixw(8'h04, 8'h11);
        check("level", 16'h0011, features.levels[0]);
        u_host.rd(3'h1, q);
        check("status", 16'h0060, q);
        for (int i = 0; i < 4; i++) begin
            ixr(8'h08 + 8'(i), q);
            check("id", ID[31 - 8 * i -: 8], q);
        end
        u_host.rd(3'h3, q);
        check("rxfill", 16'h0021, q);
        u_host.rd(3'h4, q);
        check("txfill", 16'h0012, q);
        ixw(8'h00, 8'hc0);
        check("trig", 16'h0000, features.fifo_trigger);
        depth_select_pin = 1'b0;
        $display("t_arb done");
    endtask : t_arb
    initial begin
        t_reset();
        t_depth();
        t_regs();
        t_prescale();
        t_ext();
        t_over();
        t_arb();
        end_of_test();
    end
endmodule : uart_mode_and_register_select_tb
